// ---- hw/pbt_params.svh ----
// Constants of the programmable binary timer: register offsets, field positions, reset values, timing.
// Assumes a 40 MHz pclk and a 32-bit APB with byte addresses.
`ifndef PBT_PARAMS_SVH
`define PBT_PARAMS_SVH

// Register byte offsets
`define PBT_CTRL_OFFSET 8'h00
`define PBT_STATUS_OFFSET 8'h04
`define PBT_COUNT_OFFSET 8'h08
`define PBT_OSC_DIV_OFFSET 8'h0c

// Control register fields
`define PBT_CTRL_MASTER_RESET 0
`define PBT_CTRL_AUTO_RESET_N 1
`define PBT_CTRL_POLARITY 2
`define PBT_CTRL_MODE 3
`define PBT_CTRL_DIV_SELECT0 4
`define PBT_CTRL_DIV_SELECT1 5
`define PBT_CTRL_EXT_CLOCK 6
`define PBT_CTRL_WIDTH 7

// Status register fields
`define PBT_STAT_DIVIDED 0
`define PBT_STAT_RESET_ACTIVE 1
`define PBT_STAT_POR_ACTIVE 2
`define PBT_STAT_LATCHED 3
`define PBT_STAT_STAGES_LSB 16

// Reset values
`define PBT_CTRL_RESET 7'h00
`define PBT_OSC_DIV_RESET 16'h0018

// Stage counts per select code {div_select1, div_select0}
`define PBT_STAGES_SEL00 5'd13
`define PBT_STAGES_SEL10 5'd10
`define PBT_STAGES_SEL01 5'd8
`define PBT_STAGES_SEL11 5'd16

// Timing
`define PBT_CLK_PERIOD_NS 25
`define PBT_POR_TIME_NS 1000
`define PBT_POR_CYCLES ((`PBT_POR_TIME_NS + `PBT_CLK_PERIOD_NS - 1) / `PBT_CLK_PERIOD_NS)

`endif

// ---- hw/pbt_pkg.sv ----
// Types shared by the programmable binary timer modules.
// Assumes nothing beyond a SystemVerilog elaborator.
package pbt_pkg;

  typedef enum logic [1:0] {
    PBT_ST_RESET,
    PBT_ST_COUNT,
    PBT_ST_LATCHED
  } pbt_state_t;

  typedef logic [4:0] pbt_stages_t;

endpackage : pbt_pkg

// ---- hw/pbt_ripple_counter.sv ----
// Binary counter of the timer, one toggle stage per bit.
// Assumes advance is a one-cycle pulse per rising edge of the timer clock.
module pbt_ripple_counter
  import pbt_pkg::*;
#(
  parameter int STAGES = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clear,
  input wire logic advance,
  // State
  output logic [STAGES-1:0] count
);

  logic [STAGES-1:0] carry;

  assign carry[0] = advance;

  genvar i;
  generate
    for (i = 0; i < STAGES; i++) begin : g_stage
      logic stage_reg;
      logic stage_next;
      if (i > 0) begin : g_carry
        assign carry[i] = carry[i-1] & count[i-1];
      end
      // Clear dominates so a held reset keeps every stage at zero
      assign stage_next = clear ? 1'b0 : (stage_reg ^ carry[i]);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage_reg <= 1'b0;
        end else begin
          stage_reg <= stage_next;
        end
      end
      assign count[i] = stage_reg;
    end
  endgenerate

endmodule : pbt_ripple_counter

// ---- hw/pbt_timer.sv ----
// Programmable binary timer: 16-stage counter, divider or single-shot output, APB control.
// Assumes an APB master on pclk; ext_clock_pin is asynchronous to pclk.
`include "pbt_params.svh"

module pbt_timer
  import pbt_pkg::*;
#(
  parameter int STAGES = 16,
  parameter int POR_CYCLES = `PBT_POR_CYCLES,
  parameter int OSC_DIV_WIDTH = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer pins
  input wire logic ext_clock_pin,
  output logic divided_line
);

  // APB decode
  wire apb_setup = psel & ~penable;
  wire apb_access = psel & penable;
  wire hit_ctrl = (paddr == `PBT_CTRL_OFFSET);
  wire hit_status = (paddr == `PBT_STATUS_OFFSET);
  wire hit_count = (paddr == `PBT_COUNT_OFFSET);
  wire hit_osc_div = (paddr == `PBT_OSC_DIV_OFFSET);
  wire hit_any = hit_ctrl | hit_status | hit_count | hit_osc_div;
  wire wr_ctrl = apb_access & pwrite & hit_ctrl;
  wire wr_osc_div = apb_access & pwrite & hit_osc_div;

  // Control register and its fields
  logic [`PBT_CTRL_WIDTH-1:0] ctrl_reg;
  logic [`PBT_CTRL_WIDTH-1:0] ctrl_next;
  logic [OSC_DIV_WIDTH-1:0] osc_div_reg;
  logic [OSC_DIV_WIDTH-1:0] osc_div_next;

  wire master_reset = ctrl_reg[`PBT_CTRL_MASTER_RESET];
  wire auto_reset_n = ctrl_reg[`PBT_CTRL_AUTO_RESET_N];
  wire polarity_select = ctrl_reg[`PBT_CTRL_POLARITY];
  wire mode_select = ctrl_reg[`PBT_CTRL_MODE];
  wire div_select0 = ctrl_reg[`PBT_CTRL_DIV_SELECT0];
  wire div_select1 = ctrl_reg[`PBT_CTRL_DIV_SELECT1];
  wire ext_clock_sel = ctrl_reg[`PBT_CTRL_EXT_CLOCK];

  assign ctrl_next = wr_ctrl ? pwdata[`PBT_CTRL_WIDTH-1:0] : ctrl_reg;
  assign osc_div_next = wr_osc_div ? pwdata[OSC_DIV_WIDTH-1:0] : osc_div_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `PBT_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_div_reg <= `PBT_OSC_DIV_RESET;
    end else begin
      osc_div_reg <= osc_div_next;
    end
  end

  // Power-on reset: one pulse after presetn release, only while it is enabled
  logic por_pending_reg;
  logic por_pending_next;
  logic [15:0] por_count_reg;
  logic [15:0] por_count_next;
  localparam logic [15:0] POR_LAST = 16'(POR_CYCLES - 1);

  wire por_enable = ~auto_reset_n & ~master_reset;
  wire por_active = por_pending_reg & por_enable;
  wire por_done = por_active & (por_count_reg == POR_LAST);

  // Disabling the function drops a pending pulse for good: it does not rearm later
  assign por_pending_next = (~por_pending_reg | auto_reset_n | por_done) ? 1'b0 : 1'b1;
  assign por_count_next = por_active ? (por_count_reg + 16'h0001) : 16'h0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_pending_reg <= 1'b1;
    end else begin
      por_pending_reg <= por_pending_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_count_reg <= 16'h0000;
    end else begin
      por_count_reg <= por_count_next;
    end
  end

  // Reset seen by the timer core
  wire reset_active = master_reset | por_active;

  // Internal oscillator: a pclk prescaler that halts while reset is applied
  logic [OSC_DIV_WIDTH-1:0] osc_cnt_reg;
  logic [OSC_DIV_WIDTH-1:0] osc_cnt_next;
  logic osc_out_reg;
  logic osc_out_next;
  logic osc_out_prev_reg;
  logic osc_out_prev_next;

  wire osc_wrap = (osc_cnt_reg >= osc_div_reg);
  wire osc_run = ~reset_active & ~ext_clock_sel;

  assign osc_cnt_next = !osc_run ? '0 : (osc_wrap ? '0 : osc_cnt_reg + OSC_DIV_WIDTH'(1));
  assign osc_out_next = !osc_run ? 1'b0 : (osc_wrap ? ~osc_out_reg : osc_out_reg);
  assign osc_out_prev_next = osc_out_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt_reg <= '0;
    end else begin
      osc_cnt_reg <= osc_cnt_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_out_reg <= 1'b0;
    end else begin
      osc_out_reg <= osc_out_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_out_prev_reg <= 1'b0;
    end else begin
      osc_out_prev_reg <= osc_out_prev_next;
    end
  end

  wire osc_rise = osc_out_reg & ~osc_out_prev_reg;

  // External clock pin: two-stage synchroniser, edge detect on the second stage only
  logic ext_sync1_reg;
  logic ext_sync1_next;
  logic ext_sync2_reg;
  logic ext_sync2_next;
  logic ext_prev_reg;
  logic ext_prev_next;

  assign ext_sync1_next = ext_clock_pin;
  assign ext_sync2_next = ext_sync1_reg;
  assign ext_prev_next = ext_sync2_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync1_reg <= 1'b0;
    end else begin
      ext_sync1_reg <= ext_sync1_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync2_reg <= 1'b0;
    end else begin
      ext_sync2_reg <= ext_sync2_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_prev_next;
    end
  end

  // External clock must stay below pclk/2, high and low for a pclk each, to be seen edge for edge
  wire ext_rise = ext_sync2_reg & ~ext_prev_reg;

  // Timer clock edge
  wire timer_tick = ~reset_active & (ext_clock_sel ? ext_rise : osc_rise);

  // Mode edge detection, mode comes from a pclk register so no synchroniser
  logic mode_prev_reg;
  logic mode_prev_next;

  assign mode_prev_next = mode_select;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_prev_reg <= 1'b0;
    end else begin
      mode_prev_reg <= mode_prev_next;
    end
  end

  wire mode_rise = mode_select & ~mode_prev_reg;

  // Stage count selection
  pbt_stages_t stages;
  wire [1:0] div_code = {div_select1, div_select0};

  assign stages = (div_code == 2'b00) ? `PBT_STAGES_SEL00 :
                  (div_code == 2'b10) ? `PBT_STAGES_SEL10 :
                  (div_code == 2'b01) ? `PBT_STAGES_SEL01 :
                  `PBT_STAGES_SEL11;

  // Counter
  logic [STAGES-1:0] count;
  wire counter_clear = reset_active | mode_rise;

  pbt_ripple_counter #(
    .STAGES(STAGES)
  ) u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .clear(counter_clear),
    .advance(timer_tick),
    .count(count)
  );

  // Top stage of the selected chain: toggles every 2^(n-1) ticks, period 2^n
  wire [4:0] tap_index = 5'(stages - 5'd1);
  wire tap_bit = count[tap_index[3:0]];

  // Single-shot state machine
  pbt_state_t state_reg;
  pbt_state_t state_next;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PBT_ST_RESET: begin
        if (!reset_active) begin
          state_next = PBT_ST_COUNT;
        end
      end
      PBT_ST_COUNT: begin
        if (reset_active) begin
          state_next = PBT_ST_RESET;
        end else if (!mode_select && tap_bit) begin
          state_next = PBT_ST_LATCHED;
        end
      end
      PBT_ST_LATCHED: begin
        if (reset_active) begin
          state_next = PBT_ST_RESET;
        end else if (mode_rise) begin
          state_next = PBT_ST_COUNT;
        end
      end
      default: begin
        state_next = PBT_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= PBT_ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  wire latched = (state_next == PBT_ST_LATCHED);

  // Output: polarity sets the starting level, the flip follows the mode
  logic divided_reg;
  logic divided_next;
  wire run_flip = mode_select ? tap_bit : latched;

  assign divided_next = reset_active ? polarity_select : (polarity_select ^ run_flip);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divided_reg <= 1'b0;
    end else begin
      divided_reg <= divided_next;
    end
  end

  assign divided_line = divided_reg;

  // Status word
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`PBT_STAT_DIVIDED] = divided_reg;
    status_word[`PBT_STAT_RESET_ACTIVE] = reset_active;
    status_word[`PBT_STAT_POR_ACTIVE] = por_active;
    status_word[`PBT_STAT_LATCHED] = (state_reg == PBT_ST_LATCHED);
    status_word[`PBT_STAT_STAGES_LSB +: 5] = stages;
  end

  // Read mux
  wire [31:0] rd_mux = hit_ctrl ? {{(32 - `PBT_CTRL_WIDTH){1'b0}}, ctrl_reg} :
                       hit_status ? status_word :
                       hit_count ? {{(32 - STAGES){1'b0}}, count} :
                       hit_osc_div ? {{(32 - OSC_DIV_WIDTH){1'b0}}, osc_div_reg} :
                       32'h0000_0000;

  // Read data and error are captured in the setup cycle so the access phase answers at once
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;

  assign prdata_next = (apb_setup && !pwrite) ? rd_mux : prdata_reg;
  assign pslverr_next = apb_setup ? ~hit_any : pslverr_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = apb_access & pslverr_reg;

endmodule : pbt_timer

// ---- test/pbt_timer_assertions.sv ----
// Checker for the timer: watches the APB port and the timer output.
// Assumes it is bound to pbt_timer and sees that module's ports only.
module pbt_timer_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Timer pins
  input wire logic ext_clock_pin,
  input wire logic divided_line
);
  logic [6:0] ctrl_reg;
  logic [1:0] calm_reg;
  wire acc = psel && penable;
  wire wr_ctrl = acc && pwrite && paddr == 8'h00;
  // Only judge status once control has settled for three edges
  wire calm = calm_reg == 2'h3;
  wire rd_st = acc && !pwrite && paddr == 8'h04 && calm;
  wire rd_cnt = acc && !pwrite && paddr == 8'h08 && calm;
  wire [4:0] n_exp = ctrl_reg[5:4] == 2'h0 ? 5'd13 : ctrl_reg[5:4] == 2'h1 ? 5'd8 :
    ctrl_reg[5:4] == 2'h2 ? 5'd10 : 5'd16;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 7'h00;
      calm_reg <= 2'h0;
    end else begin
      if (wr_ctrl) ctrl_reg <= pwdata[6:0];
      calm_reg <= wr_ctrl ? 2'h0 : calm_reg + {1'b0, !calm};
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_mr_holds_phase:
    assert property (calm && ctrl_reg[0] |-> divided_line == ctrl_reg[2]) else $error("output left phase in reset");
  chk_stage_code:
    assert property (rd_st |-> prdata[20:16] == n_exp) else $error("stage count wrong");
  chk_mr_count_zero:
    assert property (rd_cnt && ctrl_reg[0] |-> prdata == 32'h0) else $error("count not zero in reset");
  chk_reset_flag:
    assert property (rd_st && ctrl_reg[0] |-> prdata[1]) else $error("reset flag low");
  chk_por_off:
    assert property (rd_st && ctrl_reg[1] |-> !prdata[2]) else $error("power-on reset active");
  chk_restart_low:
    assert property ($rose(presetn) |-> divided_line == 1'b0) else $error("output not low after reset");
  chk_latch_holds:
    assert property (!ctrl_reg[3] && !ctrl_reg[0] && calm && !wr_ctrl && divided_line != ctrl_reg[2]
      |=> $stable(divided_line)) else $error("latched output moved");
  chk_mode_clears:
    assert property (wr_ctrl && pwdata[3] && !ctrl_reg[3] |-> ##3 divided_line == $past(pwdata[2], 3))
      else $error("mode rise kept latch");

  cover property (rd_st && ctrl_reg[0]);
  cover property (wr_ctrl && pwdata[3] && !ctrl_reg[3]);
  cover property (!ctrl_reg[3] && calm && divided_line != ctrl_reg[2]);
endmodule : pbt_timer_chk

bind pbt_timer pbt_timer_chk i_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ext_clock_pin(ext_clock_pin), .divided_line(divided_line));

// ---- test/pbt_board_clk.sv ----
// Board clock source driving the timer's external clock pin in bursts.
// Assumes pulses and half are set before go rises; go is held until done.
module pbt_board_clk (
  // Clock
  input wire logic pclk,
  // Burst request
  input wire logic go,
  input wire logic [16:0] pulses,
  input wire logic [3:0] half,
  output logic done,
  // Pin
  output logic ext_clock_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  int left;
  int tick;
  initial begin
    ext_clock_pin = 1'b0;
    done = 1'b0;
  end
  // Pin rests low between bursts, like a gated board clock
  always @(posedge pclk) begin
    if (!go) begin
      left <= 2 * pulses;
      tick <= 0;
      done <= 1'b0;
      ext_clock_pin <= 1'b0;
    end else if (left == 0) begin
      done <= 1'b1;
    end else if (tick + 1 >= half) begin
      ext_clock_pin <= !ext_clock_pin;
      left <= left - 1;
      tick <= 0;
    end else begin
      tick <= tick + 1;
    end
  end
endmodule : pbt_board_clk

// ---- test/pbt_timer_bench.sv ----
// Self-checking bench for pbt_timer: APB master, board clock model, row table.
// Assumes the design, the checker and the board clock model are compiled first.
`include "pbt_params.svh"

module pbt_timer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic [1:0] sel;
    logic pol;
    logic mode;
    logic [4:0] n;
    int pulses;
    logic line;
  } pbt_row_t;
  pbt_row_t rows [6] = '{
    '{2'h1, 1'b0, 1'b1, 5'd8, 128, 1'b1},
    '{2'h1, 1'b1, 1'b1, 5'd8, 256, 1'b1},
    '{2'h2, 1'b0, 1'b1, 5'd10, 512, 1'b1},
    '{2'h3, 1'b0, 1'b1, 5'd16, 300, 1'b0},
    '{2'h0, 1'b1, 1'b0, 5'd13, 4096, 1'b0},
    '{2'h1, 1'b0, 1'b0, 5'd8, 384, 1'b1}};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go, done, ext_clock_pin, divided_line, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [16:0] pulses;
  logic [3:0] half;
  int err_count = 0;
  int check_count = 0;

  pbt_timer #(.POR_CYCLES(4)) i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clock_pin(ext_clock_pin), .divided_line(divided_line));
  pbt_board_clk i_board (.pclk(pclk), .go(go), .pulses(pulses), .half(half), .done(done),
    .ext_clock_pin(ext_clock_pin));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle limit of its own: only the watchdog ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic burst(input int p, input logic [3:0] h);
    pulses <= p[16:0];
    half <= h;
    @(posedge pclk);
    go <= 1'b1;
    do begin
      @(posedge pclk);
    end while (done !== 1'b1);
    go <= 1'b0;
    @(posedge pclk);
  endtask : burst

  function automatic logic [31:0] ctl(input logic [1:0] s, input logic m, input logic p, input logic r);
    return {25'h0, 1'b1, s, m, p, 1'b1, r};
  endfunction : ctl

  task automatic print_verdict();
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // About two and a half times the cycles the sequence needs
  initial begin
    #1500000;
    err_count++;
    print_verdict();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, go, paddr, pwdata, pulses, half} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, 8'h00, ctl(rows[i].sel, rows[i].mode, rows[i].pol, 1'b1));
      apb(1'b1, 8'h00, ctl(rows[i].sel, rows[i].mode, rows[i].pol, 1'b0));
      check(divided_line, rows[i].pol);
      burst(rows[i].pulses, i == 3 ? 4'h3 : 4'h2);
      apb(1'b0, 8'h04, 32'h0);
      check(q[20:16], rows[i].n);
      check(q[2], 1'b0);
      check(q[3], !rows[i].mode);
      check(divided_line, rows[i].line);
      apb(1'b0, 8'h08, 32'h0);
      if (rows[i].mode) check(q, rows[i].pulses);
    end
    apb(1'b1, 8'h00, ctl(2'h1, 1'b1, 1'b0, 1'b0));
    apb(1'b0, 8'h08, 32'h0);
    check(q, 32'h0);
    check(divided_line, 1'b0);
    apb(1'b1, 8'h00, ctl(2'h1, 1'b1, 1'b1, 1'b1));
    burst(200, 4'h2);
    apb(1'b0, 8'h04, 32'h0);
    check(q[1], 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    check(q, 32'h0);
    check(divided_line, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    check(q, 32'h0);
    check(e, 1'b1);
    // Internal oscillator: still in master reset, then one tick per 2 * (divider + 1) pclk
    apb(1'b0, 8'h0c, 32'h0);
    check(q, `PBT_OSC_DIV_RESET);
    apb(1'b1, 8'h0c, 32'h1);
    apb(1'b1, 8'h00, ctl(2'h1, 1'b1, 1'b0, 1'b1) & 32'hffff_ffbf);
    repeat (40) @(posedge pclk);
    apb(1'b0, 8'h08, 32'h0);
    check(q, 32'h0);
    apb(1'b1, 8'h00, ctl(2'h1, 1'b1, 1'b0, 1'b0) & 32'hffff_ffbf);
    // 514 edges at 4 pclk per tick: a margin of two edges either side of the 128th tick
    repeat (512) @(posedge pclk);
    apb(1'b0, 8'h08, 32'h0);
    check(q, 32'd128);
    check(divided_line, 1'b1);
    apb(1'b1, 8'h00, ctl(2'h1, 1'b1, 1'b1, 1'b0));
    burst(100, 4'h2);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    check(q[2], 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    check(q, 32'h0);
    check(divided_line, 1'b0);
    apb(1'b0, 8'h0c, 32'h0);
    check(q, `PBT_OSC_DIV_RESET);
    print_verdict();
  end
endmodule : pbt_timer_bench
